// ==== core/can_service_cmds.sv ====
// ascii service command interpreter with wishbone registers
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/10ps
module can_service_cmds
#(
  parameter logic [7:0]  HW_VERSION = 8'h10,
  parameter logic [7:0]  FW_VERSION = 8'h10,
  // arbitrary serial characters
  parameter logic [31:0] SERIAL_NUM = 32'h4130_3031,
  parameter int          FLASH_PERIOD_CYCLES =
                           can_cmd_pkg::FLASH_PERIOD_MS * can_cmd_pkg::MS_CYCLES,
  parameter int          FLASH_ON_CYCLES =
                           can_cmd_pkg::FLASH_ON_MS * can_cmd_pkg::MS_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  input  wire logic [8:0]  rxErrCount,
  input  wire logic [8:0]  txErrCount,
  input  wire logic        warnFlag1,
  input  wire logic        warnFlag2,
  input  wire logic        rxOverflow0,
  input  wire logic        rxOverflow1,
  input  wire logic        txDone,
  input  wire logic        txOk,
  output logic             txStart,
  output logic             ctrlRestart,
  output logic             bootMode,
  output logic             redLed,
  output logic             irq,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o
);
  // ************************************************************
  // status byte
  // ************************************************************
  logic [7:0] canControllerStatusByte;

  always_comb
  begin
    canControllerStatusByte = 8'h00;
    canControllerStatusByte[can_cmd_pkg::ST_FLAG]   = warnFlag1 | warnFlag2;
    canControllerStatusByte[can_cmd_pkg::ST_RXWARN] =
      (rxErrCount > can_cmd_pkg::WARN_LIMIT) && (rxErrCount <= can_cmd_pkg::PASSIVE_LIMIT);
    canControllerStatusByte[can_cmd_pkg::ST_TXWARN] = txErrCount > can_cmd_pkg::WARN_LIMIT;
    canControllerStatusByte[can_cmd_pkg::ST_RXPASS] = rxErrCount > can_cmd_pkg::PASSIVE_LIMIT;
    canControllerStatusByte[can_cmd_pkg::ST_TXPASS] = txErrCount > can_cmd_pkg::PASSIVE_LIMIT;
    canControllerStatusByte[can_cmd_pkg::ST_BUSOFF] = txErrCount > can_cmd_pkg::BUSOFF_LIMIT;
    canControllerStatusByte[can_cmd_pkg::ST_OVF1]   = rxOverflow1;
    canControllerStatusByte[can_cmd_pkg::ST_OVF0]   = rxOverflow0;
  end

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < can_cmd_pkg::NIBBLE_TEN) ? (can_cmd_pkg::CHAR_ZERO + {4'h0, n})
                                            : (can_cmd_pkg::CHAR_A_HEX + {4'h0, n});
  endfunction : hexChar

  // ************************************************************
  // command parser and reply buffer
  // ************************************************************
  reply_if rep ();

  logic [7:0]                reply [can_cmd_pkg::REPLY_MAX];
  logic [7:0]                next_reply [can_cmd_pkg::REPLY_MAX];
  logic [5:0]                replyLen, next_replyLen, replyIdx, next_replyIdx;
  logic [7:0]                cmdFirst, next_cmdFirst;
  logic [4:0]                cmdLen, next_cmdLen;
  logic                      cmdOver, next_cmdOver;
  can_cmd_pkg::proc_state_t  state, next_state;
  logic                      next_txStart, next_ctrlRestart, next_bootMode;
  logic                      txPending, next_txPending;
  logic                      channelOpen, evReset, evBoot, evBad, evTx;
  logic [7:0]                bootMsg [can_cmd_pkg::REPLY_MAX];
  logic [8*can_cmd_pkg::BOOT_TEXT_LEN-1:0] bootText;

  // banner and prompt in full, each line closed by a carriage return
  assign bootText = "Entering Bootloader Mode...\015Boot:>\015";

  always_comb
  begin
    bootMsg = '{default: 8'h00};
    for (int i = 0; i < can_cmd_pkg::BOOT_TEXT_LEN; i++)
    begin
      bootMsg[i] = bootText[8*can_cmd_pkg::BOOT_TEXT_LEN-1-8*i -: 8];
    end
  end

  always_comb
  begin
    next_reply       = reply;
    next_replyLen    = replyLen;
    next_replyIdx    = replyIdx;
    next_cmdFirst    = cmdFirst;
    next_cmdLen      = cmdLen;
    next_cmdOver     = cmdOver;
    next_state       = state;
    next_txStart     = 1'b0;
    next_ctrlRestart = 1'b0;
    next_bootMode    = bootMode;
    next_txPending   = txPending;
    evReset          = 1'b0;
    evBoot           = 1'b0;
    evBad            = 1'b0;
    evTx             = 1'b0;
    unique case (state)
      can_cmd_pkg::P_IDLE:
      begin
        if (txPending && txDone)
        begin
          next_txPending = 1'b0;
          evTx           = 1'b1;
          next_reply[0]  = txOk ? can_cmd_pkg::CHAR_Z : can_cmd_pkg::CHAR_BELL;
          next_reply[1]  = can_cmd_pkg::CHAR_CR;
          next_replyLen  = txOk ? can_cmd_pkg::LEN_TWO : can_cmd_pkg::LEN_ONE;
          next_replyIdx  = can_cmd_pkg::LEN_ZERO;
          next_state     = can_cmd_pkg::P_SEND;
        end
        else if (rxValid && rxData != can_cmd_pkg::CHAR_CR)
        begin
          if (cmdLen == 5'h00)
          begin
            next_cmdFirst = rxData;
          end
          if (cmdLen == 5'h1F)
          begin
            next_cmdOver = 1'b1;
          end
          else
          begin
            next_cmdLen = cmdLen + 5'h01;
          end
        end
        else if (rxValid)
        begin
          next_state = can_cmd_pkg::P_LOAD;
        end
      end
      can_cmd_pkg::P_LOAD:
      begin
        next_replyIdx = can_cmd_pkg::LEN_ZERO;
        next_cmdLen   = 5'h00;
        next_cmdOver  = 1'b0;
        next_state    = can_cmd_pkg::P_SEND;
        next_reply[0] = can_cmd_pkg::CHAR_BELL;
        next_replyLen = can_cmd_pkg::LEN_ONE;
        // anything other than these answers bell
        if (!cmdOver && cmdLen == 5'h01 && cmdFirst == can_cmd_pkg::CHAR_F)
        begin
          next_reply[0] = hexChar(canControllerStatusByte[7:4]);
          next_reply[1] = hexChar(canControllerStatusByte[3:0]);
          next_reply[2] = can_cmd_pkg::CHAR_CR;
          next_replyLen = 6'h03;
        end
        else if (!cmdOver && cmdLen == 5'h01 && cmdFirst == can_cmd_pkg::CHAR_V)
        begin
          next_reply[0] = can_cmd_pkg::CHAR_V;
          next_reply[1] = hexChar(HW_VERSION[7:4]);
          next_reply[2] = hexChar(HW_VERSION[3:0]);
          next_reply[3] = hexChar(FW_VERSION[7:4]);
          next_reply[4] = hexChar(FW_VERSION[3:0]);
          next_reply[5] = can_cmd_pkg::CHAR_CR;
          next_replyLen = 6'h06;
        end
        else if (!cmdOver && cmdLen == 5'h01 && cmdFirst == can_cmd_pkg::CHAR_N)
        begin
          next_reply[0] = can_cmd_pkg::CHAR_N;
          next_reply[1] = SERIAL_NUM[31:24];
          next_reply[2] = SERIAL_NUM[23:16];
          next_reply[3] = SERIAL_NUM[15:8];
          next_reply[4] = SERIAL_NUM[7:0];
          next_reply[5] = can_cmd_pkg::CHAR_CR;
          next_replyLen = 6'h06;
        end
        else if (!cmdOver && cmdLen == 5'h01 && cmdFirst == can_cmd_pkg::CHAR_R)
        begin
          next_ctrlRestart = 1'b1;
          evReset          = 1'b1;
          next_reply[0]    = can_cmd_pkg::CHAR_CR;
        end
        else if (!cmdOver && cmdLen == 5'h01 && cmdFirst == can_cmd_pkg::CHAR_B)
        begin
          next_bootMode = 1'b1;
          evBoot        = 1'b1;
          next_reply    = bootMsg;
          next_replyLen = can_cmd_pkg::LEN_BOOT;
        end
        else if (!cmdOver && cmdFirst == can_cmd_pkg::CHAR_T && channelOpen &&
                 cmdLen >= can_cmd_pkg::EXT_HDR_LEN && !txPending)
        begin
          // only with channel open; reply waits for outcome
          next_txStart   = 1'b1;
          next_txPending = 1'b1;
          next_replyLen  = can_cmd_pkg::LEN_ZERO;
          next_state     = can_cmd_pkg::P_IDLE;
        end
        else
        begin
          evBad = 1'b1;
        end
      end
      can_cmd_pkg::P_SEND:
      begin
        if (replyIdx == replyLen)
        begin
          // leave only once the last byte has gone out
          if (!rep.busy)
          begin
            // bootloader is left only by sys_rst
            next_state = bootMode ? can_cmd_pkg::P_LOCK : can_cmd_pkg::P_IDLE;
          end
        end
        else if (rep.ready)
        begin
          next_replyIdx = replyIdx + 6'h01;
        end
      end
      can_cmd_pkg::P_LOCK:
      begin
        next_state = can_cmd_pkg::P_LOCK;
      end
    endcase
  end

  assign rep.valid = (state == can_cmd_pkg::P_SEND) && (replyIdx != replyLen);
  assign rep.data  = reply[replyIdx];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < can_cmd_pkg::REPLY_MAX; i++)
      begin
        reply[i] <= 8'h00;
      end
      replyLen    <= can_cmd_pkg::LEN_ZERO;
      replyIdx    <= can_cmd_pkg::LEN_ZERO;
      cmdFirst    <= 8'h00;
      cmdLen      <= 5'h00;
      cmdOver     <= 1'b0;
      state       <= can_cmd_pkg::P_IDLE;
      txStart     <= 1'b0;
      ctrlRestart <= 1'b0;
      bootMode    <= 1'b0;
      txPending   <= 1'b0;
    end
    else if (clkEn)
    begin
      reply       <= next_reply;
      replyLen    <= next_replyLen;
      replyIdx    <= next_replyIdx;
      cmdFirst    <= next_cmdFirst;
      cmdLen      <= next_cmdLen;
      cmdOver     <= next_cmdOver;
      state       <= next_state;
      txStart     <= next_txStart;
      ctrlRestart <= next_ctrlRestart;
      bootMode    <= next_bootMode;
      txPending   <= next_txPending;
    end
  end

  reply_sender u_sender
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .rep     (rep.tx),
    .txData  (txData),
    .txValid (txValid),
    .txReady (txReady)
  );

  // ************************************************************
  // red indicator
  // ************************************************************
  logic [31:0] flashCount, next_flashCount;
  logic        next_redLed;

  always_comb
  begin
    next_flashCount = (flashCount >= FLASH_PERIOD_CYCLES - 1) ? 32'h0000_0000
                                                              : flashCount + 32'h0000_0001;
    next_redLed = 1'b0;
    if (canControllerStatusByte[can_cmd_pkg::ST_BUSOFF])
    begin
      next_redLed = 1'b1;
    end
    else if (canControllerStatusByte[can_cmd_pkg::ST_RXPASS] |
             canControllerStatusByte[can_cmd_pkg::ST_TXPASS])
    begin
      next_redLed = flashCount < FLASH_ON_CYCLES;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flashCount <= 32'h0000_0000;
      redLed     <= 1'b0;
    end
    else if (clkEn)
    begin
      flashCount <= next_flashCount;
      redLed     <= next_redLed;
    end
  end

  // ************************************************************
  // wishbone registers and interrupt
  // ************************************************************
  logic                              ctrlOpen, next_ctrlOpen, next_ack;
  logic [can_cmd_pkg::IRQ_WIDTH-1:0] irqStatus, next_irqStatus, irqMask, next_irqMask;
  logic [31:0]                       next_datO;
  logic                              wbWrite;
  logic [3:0]                        events;

  assign channelOpen = ctrlOpen;
  assign wbWrite     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign events      = {evTx, evBad, evBoot, evReset};
  assign irq         = |(irqStatus & irqMask);

  always_comb
  begin
    next_ack       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_ctrlOpen  = ctrlOpen;
    next_irqMask   = irqMask;
    next_irqStatus = irqStatus;
    next_datO      = 32'h0000_0000;
    if (wbWrite && wb_adr_i == can_cmd_pkg::ADDR_CTRL)
    begin
      next_ctrlOpen = wb_dat_i[can_cmd_pkg::CTRL_OPEN];
    end
    if (wbWrite && wb_adr_i == can_cmd_pkg::ADDR_MASK)
    begin
      next_irqMask = wb_dat_i[can_cmd_pkg::IRQ_WIDTH-1:0];
    end
    if (wbWrite && wb_adr_i == can_cmd_pkg::ADDR_IRQ)
    begin
      next_irqStatus = irqStatus & ~wb_dat_i[can_cmd_pkg::IRQ_WIDTH-1:0];
    end
    // a new event wins over a clear in the same cycle
    next_irqStatus = next_irqStatus | (clkEn ? events : 4'h0);
    unique case (wb_adr_i)
      can_cmd_pkg::ADDR_CTRL:   next_datO = {30'h0, bootMode, ctrlOpen};
      can_cmd_pkg::ADDR_STATUS: next_datO = {24'h00_0000, canControllerStatusByte};
      can_cmd_pkg::ADDR_IRQ:    next_datO = {28'h000_0000, irqStatus};
      can_cmd_pkg::ADDR_MASK:   next_datO = {28'h000_0000, irqMask};
      can_cmd_pkg::ADDR_VER:    next_datO = {16'h0000, HW_VERSION, FW_VERSION};
      can_cmd_pkg::ADDR_SERIAL: next_datO = SERIAL_NUM;
      default:                  next_datO = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      ctrlOpen  <= 1'b0;
      irqMask   <= 4'h0;
      irqStatus <= 4'h0;
    end
    else
    begin
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_datO;
      ctrlOpen  <= next_ctrlOpen;
      irqMask   <= next_irqMask;
      irqStatus <= next_irqStatus;
    end
  end
endmodule : can_service_cmds

// ==== core/can_cmd_pkg.sv ====
// constants and types for the ascii service command handler
package can_cmd_pkg;
  // ascii characters
  localparam logic [7:0] CHAR_CR    = 8'h0D;
  localparam logic [7:0] CHAR_BELL  = 8'h07;
  localparam logic [7:0] CHAR_F     = 8'h46;
  localparam logic [7:0] CHAR_V     = 8'h56;
  localparam logic [7:0] CHAR_N     = 8'h4E;
  localparam logic [7:0] CHAR_R     = 8'h52;
  localparam logic [7:0] CHAR_B     = 8'h42;
  localparam logic [7:0] CHAR_T     = 8'h54;
  localparam logic [7:0] CHAR_Z     = 8'h5A;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] CHAR_A_HEX = 8'h37;
  localparam logic [3:0] NIBBLE_TEN = 4'h0A;
  // error counter thresholds
  localparam logic [8:0] WARN_LIMIT    = 9'h05F;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
  // status byte bit positions
  localparam int ST_FLAG   = 0;
  localparam int ST_RXWARN = 1;
  localparam int ST_TXWARN = 2;
  localparam int ST_RXPASS = 3;
  localparam int ST_TXPASS = 4;
  localparam int ST_BUSOFF = 5;
  localparam int ST_OVF1   = 6;
  localparam int ST_OVF0   = 7;
  // wishbone register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_VER    = 8'h10;
  localparam logic [7:0] ADDR_SERIAL = 8'h14;
  // control register fields
  localparam int CTRL_OPEN = 0;
  localparam int CTRL_BOOT = 1;
  // interrupt bit positions
  localparam int IRQ_RESET  = 0;
  localparam int IRQ_BOOT   = 1;
  localparam int IRQ_BADCMD = 2;
  localparam int IRQ_TX     = 3;
  localparam int IRQ_WIDTH  = 4;
  // reply buffer, big enough for the whole bootloader banner
  localparam int REPLY_MAX = 64;
  localparam logic [5:0] LEN_ZERO = 6'h00;
  localparam logic [5:0] LEN_ONE  = 6'h01;
  localparam logic [5:0] LEN_TWO  = 6'h02;
  localparam logic [5:0] LEN_BOOT = 6'h23;
  localparam int BOOT_TEXT_LEN = 35;
  // led single flash: period and on time in ms
  localparam int FLASH_PERIOD_MS = 1000;
  localparam int FLASH_ON_MS     = 200;
  localparam int CLK_HZ          = 25000000;
  localparam int MS_CYCLES       = CLK_HZ / 1000;
  // length of an extended transmit command: T + 8 id + length digit
  localparam logic [4:0] EXT_HDR_LEN = 5'h0A;
  typedef enum logic [1:0] {
    P_IDLE  = 2'b00,
    P_LOAD  = 2'b01,
    P_SEND  = 2'b11,
    P_LOCK  = 2'b10
  } proc_state_t;
endpackage : can_cmd_pkg

// ==== core/reply_if.sv ====
// reply byte stream between command core and transmitter
`timescale 1ns/10ps
interface reply_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       busy;
  modport core (output data, output valid, input ready, input busy);
  modport tx   (input data, input valid, output ready, output busy);
endinterface : reply_if

// ==== core/reply_sender.sv ====
// serialises one reply byte at a time onto the byte output
`timescale 1ns/10ps
module reply_sender
(
  input  wire logic    clk,
  input  wire logic    sys_rst,
  input  wire logic    clkEn,
  reply_if.tx          rep,
  output logic [7:0]   txData,
  output logic         txValid,
  input  wire logic    txReady
);
  logic [7:0] next_txData;
  logic       next_txValid;

  // stalls the core while the host side is not ready
  assign rep.ready = !txValid || txReady;
  assign rep.busy  = txValid;

  always_comb
  begin
    next_txData  = txData;
    next_txValid = txValid;
    if (txValid && txReady)
    begin
      next_txValid = 1'b0;
    end
    if (rep.valid && rep.ready)
    begin
      next_txData  = rep.data;
      next_txValid = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txData  <= 8'h00;
      txValid <= 1'b0;
    end
    else if (clkEn)
    begin
      txData  <= next_txData;
      txValid <= next_txValid;
    end
  end
endmodule : reply_sender

// ==== tb/can_service_cmds_props.sv ====
// assertion checker for the service command block
`timescale 1ns/10ps
module can_service_cmds_props
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [8:0] rxErrCount,
  input wire logic [8:0] txErrCount,
  input wire logic [7:0] txData,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       txStart,
  input wire logic       ctrlRestart,
  input wire logic       bootMode,
  input wire logic       redLed,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // named steps
  // ****
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sBusOff;
    (txErrCount > can_cmd_pkg::BUSOFF_LIMIT) [*3];
  endsequence
  // three cycles so a registered led has settled
  sequence sActive;
    (txErrCount <= can_cmd_pkg::PASSIVE_LIMIT && rxErrCount <= can_cmd_pkg::PASSIVE_LIMIT) [*3];
  endsequence
  a_ack_next:
    assert property (sReq |=> wb_ack_o) else $error("ack late");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_reply_holds:
    assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte lost");
  a_busoff_led:
    assert property (sBusOff |-> redLed) else $error("red led not held");
  a_active_dark:
    assert property (sActive |-> !redLed) else $error("red led lit");
  a_start_pulse:
    assert property (txStart |=> !txStart) else $error("start too long");
  a_restart_pulse:
    assert property (ctrlRestart |=> !ctrlRestart) else $error("restart too long");
  a_boot_sticky:
    assert property (bootMode |=> bootMode) else $error("boot mode left");
  a_boot_silent:
    assert property (bootMode |-> !txStart && !ctrlRestart) else $error("boot mode acts");
endmodule : can_service_cmds_props
bind can_service_cmds can_service_cmds_props CHK
(
  .clk(clk), .sys_rst(sys_rst), .rxErrCount(rxErrCount), .txErrCount(txErrCount),
  .txData(txData), .txValid(txValid), .txReady(txReady), .txStart(txStart),
  .ctrlRestart(ctrlRestart), .bootMode(bootMode), .redLed(redLed),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

// ==== tb/host_link_model.sv ====
// host side of the command byte stream
`timescale 1ns/10ps
module host_link_model
(
  input  wire logic       clk,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady
);
  logic       slow = 1'b0;
  logic [7:0] replyQ[$];
  initial
  begin
    rxData  = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  // ****
  // reply capture, slow mode stalls every other cycle
  // ****
  always @(posedge clk)
  begin
    if (txValid && txReady)
      replyQ.push_back(txData);
    txReady <= slow ? ~txReady : 1'b1;
  end
  // every command closes with a carriage return
  task automatic send_line(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk);
      rxData  <= (i == s.len()) ? 8'h0D : s[i];
      rxValid <= 1'b1;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    // idle data is not held, so a stale byte cannot pass for a new one
    rxData  <= ~rxData;
  endtask : send_line
endmodule : host_link_model

// ==== tb/can_service_cmds_tb.sv ====
// self-checking bench for the service command block
`timescale 1ns/10ps
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin errCount++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module can_service_cmds_tb;
  localparam logic [7:0]  HW  = 8'h21;
  localparam logic [7:0]  FW  = 8'h13;
  // arbitrary serial characters
  localparam logic [31:0] SER = 32'h4B37_3039;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  rxData, txData;
  logic        rxValid, txValid, txReady, txStart, ctrlRestart, bootMode, redLed, irq;
  logic        txDone = 1'b0, txOk = 1'b0, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbAck;
  logic [8:0]  rxErr = 9'h000, txErr = 9'h000;
  logic [3:0]  canIn = 4'h0;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0000_0000, wbDatO;
  int          errCount = 0, checksDone = 0, startCnt = 0, restartCnt = 0;
  // rx count, tx count, flag1, flag2, overflow0, overflow1
  logic [21:0] cases [8] = '{{9'h05F, 9'h000, 4'h0}, {9'h060, 9'h000, 4'h8},
    {9'h07F, 9'h05F, 4'h4}, {9'h080, 9'h060, 4'h2}, {9'h000, 9'h07F, 4'h1},
    {9'h000, 9'h080, 4'h0}, {9'h000, 9'h0FF, 4'h0}, {9'h000, 9'h100, 4'h0}};
  string       boot = "Entering Bootloader Mode...\015Boot:>\015";
  always #20 clk = ~clk;
  can_service_cmds #(.HW_VERSION(HW), .FW_VERSION(FW), .SERIAL_NUM(SER),
    .FLASH_PERIOD_CYCLES(20), .FLASH_ON_CYCLES(4)) DUT
  (
    .clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxErrCount(rxErr),
    .txErrCount(txErr), .warnFlag1(canIn[3]), .warnFlag2(canIn[2]),
    .rxOverflow0(canIn[1]), .rxOverflow1(canIn[0]), .txDone(txDone), .txOk(txOk),
    .txStart(txStart), .ctrlRestart(ctrlRestart), .bootMode(bootMode), .redLed(redLed),
    .irq(irq), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_sel_i(4'hF),
    .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck)
  );
  host_link_model HOST
  (
    .clk(clk), .rxData(rxData), .rxValid(rxValid), .txData(txData), .txValid(txValid),
    .txReady(txReady)
  );
  always @(posedge clk)
  begin
    startCnt   <= startCnt + int'(txStart);
    restartCnt <= restartCnt + int'(ctrlRestart);
  end
  // ****
  // helpers
  // ****
  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hexc
  function automatic logic [7:0] expStatus(input logic [21:0] c);
    expStatus = {c[1], c[0], c[12:4] > 9'h0FF, c[12:4] > 9'h07F, c[21:13] > 9'h07F,
      c[12:4] > 9'h05F, c[21:13] > 9'h05F && c[21:13] <= 9'h07F, c[3] | c[2]};
  endfunction : expStatus
  task automatic reportAndStop();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : reportAndStop
  task automatic tmo();
    errCount++;
    reportAndStop();
  endtask : tmo
  // one classic cycle, held until ack is sampled
  task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                        output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbAdr  <= a;
    wbWe   <= we;
    wbDatI <= d;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    do
      @(posedge clk);
    while (wbAck !== 1'b1 && ++n < 50);
    if (n >= 50)
      tmo();
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer
  task automatic expectQ(input logic [7:0] e[$]);
    int n;
    n = 0;
    while (HOST.replyQ.size() < e.size() && ++n < 2000)
      @(posedge clk);
    if (n >= 2000)
      tmo();
    // a few more cycles so a surplus byte shows up
    repeat (8) @(posedge clk);
    `CHECK(HOST.replyQ.size(), e.size())
    foreach (e[i])
      if (i < HOST.replyQ.size())
        `CHECK(HOST.replyQ[i], e[i])
    HOST.replyQ.delete();
  endtask : expectQ
  task automatic extTx(input logic ok);
    int n;
    n = startCnt;
    HOST.send_line("T123456780");
    for (int k = 0; k < 100 && startCnt == n; k++)
      @(posedge clk);
    if (startCnt == n)
      tmo();
    txDone <= 1'b1;
    txOk   <= ok;
    @(posedge clk);
    txDone <= 1'b0;
  endtask : extTx
  // ****
  // main sequence
  // ****
  initial
  begin
    logic [31:0] rd;
    logic [7:0]  st;
    logic [7:0]  bq[$];
    logic        a;
    int          on;
    int          n;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    wbXfer(can_cmd_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000, rd);
    `CHECK(rd, 32'h0000_0000)
    `CHECK(redLed, 1'b0)
    wbXfer(8'h40, 1'b1, 32'hFFFF_FFFF, rd);
    wbXfer(8'h40, 1'b0, 32'h0000_0000, rd);
    `CHECK(rd, 32'h0000_0000)
    HOST.send_line("Q");
    expectQ({8'h07});
    wbXfer(can_cmd_pkg::ADDR_IRQ, 1'b0, 32'h0000_0000, rd);
    `CHECK(rd[can_cmd_pkg::IRQ_BADCMD], 1'b1)
    wbXfer(can_cmd_pkg::ADDR_MASK, 1'b1, 32'h0000_0000, rd);
    @(posedge clk);
    a = irq;
    wbXfer(can_cmd_pkg::ADDR_MASK, 1'b1, 32'h0000_000F, rd);
    @(posedge clk);
    // only one of the two mask settings lets the event through
    `CHECK(a ^ irq, 1'b1)
    wbXfer(can_cmd_pkg::ADDR_IRQ, 1'b1, 32'h0000_000F, rd);
    wbXfer(can_cmd_pkg::ADDR_IRQ, 1'b0, 32'h0000_0000, rd);
    `CHECK(rd[3:0], 4'h0)
    `CHECK(irq, 1'b0)
    for (int i = 0; i < 8; i++)
    begin
      {rxErr, txErr, canIn} <= cases[i];
      HOST.slow = i[0];
      repeat (3) @(posedge clk);
      st = expStatus(cases[i]);
      HOST.send_line("F");
      expectQ({hexc(st[7:4]), hexc(st[3:0]), 8'h0D});
      wbXfer(can_cmd_pkg::ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      `CHECK(rd[7:0], st)
      on = 0;
      repeat (40) @(posedge clk) on += int'(redLed);
      `CHECK(on, st[5] ? 40 : (st[4:3] != 2'b00) ? 8 : 0)
    end
    {rxErr, txErr, canIn} <= 22'h00_0000;
    HOST.slow = 1'b0;
    HOST.send_line("V");
    expectQ({8'h56, hexc(HW[7:4]), hexc(HW[3:0]), hexc(FW[7:4]), hexc(FW[3:0]), 8'h0D});
    wbXfer(can_cmd_pkg::ADDR_VER, 1'b0, 32'h0000_0000, rd);
    `CHECK(rd[15:0], {HW, FW})
    HOST.send_line("N");
    expectQ({8'h4E, SER[31:24], SER[23:16], SER[15:8], SER[7:0], 8'h0D});
    HOST.send_line("T123456780");
    expectQ({8'h07});
    `CHECK(startCnt, 0)
    // channel opened before frames go out
    wbXfer(can_cmd_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001, rd);
    extTx(1'b1);
    expectQ({8'h5A, 8'h0D});
    extTx(1'b0);
    expectQ({8'h07});
    n = restartCnt;
    HOST.send_line("R");
    expectQ({8'h0D});
    `CHECK(restartCnt, n + 1)
    for (int i = 0; i < boot.len(); i++)
      bq.push_back(boot[i]);
    HOST.send_line("B");
    expectQ(bq);
    `CHECK(bootMode, 1'b1)
    HOST.send_line("V");
    repeat (40) @(posedge clk);
    `CHECK(HOST.replyQ.size(), 0)
    reportAndStop();
  end
endmodule : can_service_cmds_tb
